// ---- bench/sdlc_channel_controller_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdlc_channel_controller_bench
	import sdlcc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  aa = 8'h00;
	logic [7:0]  ra = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0]  ws = 4'h0;
	logic        av = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic [15:0] td = 16'h0;
	logic        awr, wrd, bv, arr, rvl, txc, txd, rxc, rxd, we;
	logic [1:0]  brs, rrs, rsp;
	logic [31:0] rdt, rv;
	logic [10:0] tad, rad;
	logic [15:0] rdat;
	logic [3:0]  irq;
	logic [15:0] txm [2048];
	logic [15:0] rxm [2048];
	int          fails = 0;
	int          comparisons = 0;
	logic [31:0] seed = 32'h434D00BE;
	logic [6:0]  ctl = 7'h00;
	logic        iad = 1'b0;
	////////////////////////////////
	sdlcc_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_awaddr(aa),
		.i_awvalid(av), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws),
		.i_wvalid(wv), .o_wready(wrd), .o_bresp(brs), .o_bvalid(bv),
		.i_bready(br), .i_araddr(ra), .i_arvalid(arv), .o_arready(arr),
		.o_rdata(rdt), .o_rresp(rrs), .o_rvalid(rvl), .i_rready(rr),
		.o_tx_clk(txc), .o_tx_data(txd), .i_rx_clk(rxc), .i_rx_data(rxd),
		.o_tx_ram_addr(tad), .i_tx_ram_data(td), .o_rx_ram_addr(rad),
		.o_rx_ram_data(rdat), .o_rx_ram_we(we), .o_irq(irq));
	sdlcc_station stn (.i_tx_clk(txc), .i_tx_data(txd), .o_rx_clk(rxc),
		.o_rx_data(rxd));
	// Clock, and the two buffer ports with a one-cycle read.
	always #20 clk = ~clk;
	always @(posedge clk) begin
		td <= txm[tad];
		if (we) rxm[rad] <= rdat;
	end
	////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic end_sim;
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 9000) begin
			fails++;
			$display("wrong value at %0t: wait ran out", $time);
			end_sim();
		end
	endtask : tmo
	// Bus master: valids held until their ready edge, answers taken there.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{aa, wd, ws, av, wv, br} <= {a, d, 4'hF, 3'h7};
		for (n = 0; n < 9000; n++) begin
			@(posedge clk);
			if (awr) av <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		tmo(n);
		rsp = brs;
		br <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		{ra, arv, rr} <= {a, 2'h3};
		for (n = 0; n < 9000; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rvl) break;
		end
		tmo(n);
		{rsp, rv} = {rrs, rdt};
		rr <= 1'b0;
	endtask : rd
	task automatic ctlw(input logic [31:0] x);
		wr(A_CTL, {25'h0, ctl} | (32'(iad) << B_IADW) | x);
	endtask : ctlw
	task automatic wait_send;
		int n;
		for (n = 0; n < 9000; n++) begin
			rd(A_CTL);
			if (rv[B_SEND] === 1'b1) break;
		end
		tmo(n);
	endtask : wait_send
	task automatic wait_fr(input int f);
		int n;
		for (n = 0; n < 9000 && stn.frames < f; n++) @(posedge clk);
		tmo(n);
	endtask : wait_fr
	////////////////////////////////
	// Main sequence: registers, transmit, abort, then receive.
	initial begin
		int n, a0, adr;
		logic [15:0] q[$];
		for (n = 0; n < 16; n++) txm[n] = 16'(xs());
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_CTL);
		chk(rv, 32'h0);
		rd(8'h08);
		chk({rsp, rv[29:0]}, {RESP_ERR, 30'h0});
		wr(8'h0C, 32'hFFFFFFFF);
		chk(32'(rsp), 32'(RESP_ERR));
		wr(A_AUX, 32'h1);
		ctlw(32'h1 << B_LTS);
		ctl = 7'h0D;
		ctlw((32'h3 << B_AIN) | (32'h1 << B_LTE));
		wait_send();
		ctlw((32'h5 << B_AIN) | (32'h1 << B_LTE));
		wait_fr(2);
		for (n = 0; n < 6; n++) chk(32'(stn.got_q[n]), 32'(txm[n]));
		rd(A_CTL);
		chk(32'(rv[10:0]), 32'h08C);
		chk(32'(irq), 32'h3);
		ctl = 7'h0C;
		ctlw(32'h0);
		rd(A_CTL);
		chk(32'(rv[B_FD]), 32'h0);
		wr(A_AUX, 32'hF00);
		// The lines follow the status one clock later.
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		// Idle after done, interrupts masked but status still latched.
		{iad, ctl} = 8'h81;
		ctlw((32'h6 << B_AIN) | (32'h1 << B_LTE));
		rd(A_CTL);
		chk(32'(rv[10:9]), 32'h3);
		wait_fr(3);
		chk(32'(stn.got_q[6]), 32'(txm[6]));
		repeat (160) @(posedge clk);
		chk(32'(stn.ones >= 15 && txd === 1'b1), 32'h1);
		rd(A_AUX);
		chk({rv[9:8], 2'(irq)}, 4'hC);
		// Abort ignored while idle, honoured mid-frame.
		iad = 1'b0;
		a0 = stn.aborts;
		ctlw(32'h1 << B_ABT);
		repeat (240) @(posedge clk);
		chk(32'(stn.aborts), 32'(a0));
		ctlw(32'h1 << B_LTS);
		ctlw((32'hF << B_AIN) | (32'h1 << B_LTE));
		wait_send();
		ctlw(32'h1 << B_ABT);
		for (n = 0; n < 9000 && stn.aborts == a0; n++) @(posedge clk);
		tmo(n);
		chk(32'(stn.frames), 32'h3);
		rd(A_CTL);
		chk(32'(rv[B_SEND]), 32'h0);
		// Shared zeros make repeated flags seven bits long, not eight.
		ctl = 7'h41;
		ctlw(32'h0);
		a0 = stn.flags;
		repeat (2048) @(posedge clk);
		chk(32'(stn.flags - a0 >= 34), 32'h1);
		// Two received frames stored back to back.
		ctl = 7'h33;
		ctlw((32'h10 << B_AIN) | (32'h1 << B_LRS));
		adr = 16;
		for (int f = 0; f < 2; f++) begin
			wr(A_AUX, 32'h400);
			q.delete();
			for (n = 0; n < 3 - f; n++) q.push_back(16'(xs()));
			stn.send_frame(q);
			repeat (40) @(posedge clk);
			foreach (q[i]) chk(32'(rxm[adr + i]), 32'(q[i]));
			adr += q.size();
			rd(A_CTL);
			chk(32'(rv[29:19]), 32'(adr - 1));
			chk(32'(irq[2]), 32'h1);
		end
		stn.send_abort();
		repeat (40) @(posedge clk);
		rd(A_CTL);
		chk({rv[30], irq[3]}, 2'h3);
		ctlw(32'h1 << B_ABD);
		rd(A_CTL);
		chk(32'(rv[B_ABD]), 32'h0);
		stn.send_idle();
		repeat (40) @(posedge clk);
		rd(A_CTL);
		chk(32'(rv[B_IDD]), 32'h1);
		end_sim();
	end
endmodule : sdlc_channel_controller_bench
`default_nettype wire

// ---- bench/sdlcc_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// Pin-level checks on the bus handshake and the outgoing link.
module sdlcc_chk
	import sdlcc_pkg::*;
(
	// Clock and reset.
	input wire logic        i_clk_sys,
	input wire logic        i_reset_n,
	// Register bus.
	input wire logic        o_awready,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic [1:0]  o_bresp,
	input wire logic        i_bready,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp,
	input wire logic        i_rready,
	// Link and buffer.
	input wire logic        o_tx_clk,
	input wire logic        o_tx_data,
	input wire logic        o_rx_ram_we
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////
	// A write taken on both channels is answered within two edges.
	sequence s_wr_taken; o_awready && o_wready; endsequence
	sequence s_wr_answer; ##[1:2] o_bvalid; endsequence
	property p_wr_answer; s_wr_taken |-> s_wr_answer; endproperty
	property p_b_hold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	property p_rd_answer; o_arready |=> o_rvalid; endproperty
	property p_r_hold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	property p_err_zero;
		o_rvalid && o_rresp == RESP_ERR |-> o_rdata == 32'h0;
	endproperty
	////////////////////////////////
	// Data moves only as the link clock falls, so the far end sees it
	// settled for a whole half period.
	property p_tx_edge; $changed(o_tx_data) |-> $fell(o_tx_clk); endproperty
	property p_tx_half; $rose(o_tx_clk) |-> o_tx_clk [*4] ##1 !o_tx_clk;
	endproperty
	property p_we_gap; o_rx_ram_we |=> !o_rx_ram_we [*8]; endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write not answered");
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	a_r_hold: assert property (p_r_hold)
		else $error("read answer dropped");
	a_err_zero: assert property (p_err_zero)
		else $error("error read with data");
	a_tx_edge: assert property (p_tx_edge)
		else $error("link data moved off falling clock");
	a_tx_half: assert property (p_tx_half)
		else $error("link clock half period wrong");
	a_we_gap: assert property (p_we_gap)
		else $error("buffer writes too close");
endmodule : sdlcc_chk

bind sdlcc_top sdlcc_chk u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
	.o_bresp(o_bresp), .i_bready(i_bready), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
	.i_rready(i_rready), .o_tx_clk(o_tx_clk), .o_tx_data(o_tx_data),
	.o_rx_ram_we(o_rx_ram_we));
`default_nettype wire

// ---- bench/sdlcc_station.sv ----
`timescale 1ns/100ps
`default_nettype none
// Remote station: decodes the block's frames and sends frames back.
module sdlcc_station
	import sdlcc_pkg::*;
(
	// From the block.
	input wire logic i_tx_clk,
	input wire logic i_tx_data,
	// To the block.
	output logic     o_rx_clk,
	output logic     o_rx_data
);
	logic [15:0] got_q[$];
	bit          bits_q[$];
	int          frames = 0;
	int          flags = 0;
	int          aborts = 0;
	int          ones = 0;
	int          txones = 0;
	logic [15:0] w;
	initial begin
		o_rx_clk = 1'b0;
		o_rx_data = 1'b1;
	end
	// Drop stuffed zeros, split at flags, pack words low bit first.
	always @(posedge i_tx_clk) begin
		if (i_tx_data === 1'b1) begin
			ones++;
			if (ones == 7) aborts++;
			if (ones >= 7) bits_q.delete();
			else bits_q.push_back(1'b1);
		end else begin
			if (ones == 6) begin
				flags++;
				repeat (7) if (bits_q.size() > 0) void'(bits_q.pop_back());
				if (bits_q.size() >= 16) frames++;
				while (bits_q.size() >= 16) begin
					for (int i = 0; i < 16; i++) w[i] = bits_q.pop_front();
					got_q.push_back(w);
				end
				bits_q.delete();
			end else if (ones != 5) bits_q.push_back(1'b0);
			ones = 0;
		end
	end
	// The clock runs only inside a burst; data moves while it is low.
	task automatic put(input logic b);
		o_rx_data = b;
		#160 o_rx_clk = 1'b1;
		#160 o_rx_clk = 1'b0;
	endtask : put
	task automatic put_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) put(v[i]);
		txones = 0;
	endtask : put_byte
	task automatic put_word(input logic [15:0] v);
		for (int i = 0; i < 16; i++) begin
			put(v[i]);
			txones = v[i] ? txones + 1 : 0;
			if (txones == 5) begin
				put(1'b0);
				txones = 0;
			end
		end
	endtask : put_word
	// A released line shows the inverse, never a stale level.
	task automatic send_frame(input logic [15:0] q[$]);
		#7 put_byte(FLAG);
		foreach (q[i]) put_word(q[i]);
		put_byte(FLAG);
		o_rx_data = ~o_rx_data;
	endtask : send_frame
	task automatic send_abort;
		#7 put_byte(FLAG);
		put_word(16'h1234);
		repeat (8) put(1'b1);
		put_byte(FLAG);
		o_rx_data = ~o_rx_data;
	endtask : send_abort
	task automatic send_idle;
		#7 put_byte(FLAG);
		repeat (16) put(1'b1);
		o_rx_data = ~o_rx_data;
	endtask : send_idle
endmodule : sdlcc_station
`default_nettype wire

// ---- src/sdlcc_pkg.sv ----
package sdlcc_pkg;

	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [7:0] A_CTL = 8'h00;
	localparam logic [7:0] A_AUX = 8'h04;

	// Main control and status word fields.
	localparam int B_TXEN = 0;
	localparam int B_RXEN = 1;
	localparam int B_CTLW = 7;
	localparam int B_FD   = 7;
	localparam int B_SEND = 8;
	localparam int B_IADR = 9;
	localparam int B_AIN  = 8;
	localparam int B_IADW = 19;
	localparam int B_LRS  = 20;
	localparam int B_LTS  = 21;
	localparam int B_LTE  = 22;
	localparam int B_ABT  = 23;
	localparam int B_REA  = 19;
	localparam int B_ABD  = 30;
	localparam int B_IDD  = 31;

	// Auxiliary word fields.
	localparam int B_TCE = 0;
	localparam int B_IST = 8;

	// Reset values.
	localparam logic [6:0]  CTL_RST  = 7'h00;
	localparam logic [10:0] ADDR_RST = 11'h000;

	// Link characters and bit-run limits.
	localparam logic [7:0] FLAG      = 8'h7E;
	localparam logic [7:0] TX_ABORT  = 8'hFE;
	localparam logic [4:0] MARK_BITS = 5'h0F;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [3:0] RX_ABORT  = 4'h6;
	localparam logic [3:0] RX_IDLE   = 4'hE;

	// Link bit timing.
	localparam int CLK_NS  = 40;
	localparam int HALF_NS = 160;
	localparam int HALF_CYC = HALF_NS / CLK_NS;

	// Bus responses.
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		TX_OFF,
		TX_FLAG,
		TX_DATA,
		TX_ABRT,
		TX_MARK
	} sdlcc_tx_t;

endpackage : sdlcc_pkg

// ---- src/sdlcc_top.sv ----
// Summary of operation
// - Transmit enable sends start through end address.
// - Receive stores first at start, then after.
// - Clear enable drops transmit enable when idle.
// - Transmit status latches, first line when enabled.
// - Frame-done status latches, second line when enabled.
// - Flag after message ends it, third line.
// - Received abort latches status, fourth line.
// - Repeated flags may share one zero.
// - Frame done latched, cleared by control write.
// - New end address queues the next frame.
// - Without new starts, continue after previous end.
// - Sending-data reads one only during data.
// - Status shows idle-after-done selection.
// - Idle sends fifteen ones, holds line high.
// - Load strobes copy address field to register.
// - Send-abort emits abort only mid-transmission.
// - Receive end address is last word stored.
// - Abort detected latches until written one.
// - Idle detected latches until written one.
// - Load strobes at bits 20, 21, 22.
`timescale 1ns/100ps
`default_nettype none

module sdlcc_top
	import sdlcc_pkg::*;
(
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	// AXI4-Lite slave.
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Serial link.
	output logic             o_tx_clk,
	output logic             o_tx_data,
	input  wire logic        i_rx_clk,
	input  wire logic        i_rx_data,
	// Transmit buffer read port.
	output logic [10:0]      o_tx_ram_addr,
	input  wire logic [15:0] i_tx_ram_data,
	// Receive buffer write port.
	output logic [10:0]      o_rx_ram_addr,
	output logic [15:0]      o_rx_ram_data,
	output logic             o_rx_ram_we,
	// Interrupt lines.
	output logic [3:0]       o_irq
);

	////////////////////////////////////////////////////////////////////
	// Declarations.

	logic        aw_h;
	logic        w_h;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic [31:0] wm;
	logic [31:0] wmq;
	logic        wr;
	logic        wr_ctl;
	logic        wr_aux;
	logic [6:0]  ctl;
	logic        iad;
	logic        tce;
	logic        fd;
	logic [3:0]  ist;
	logic        abd;
	logic        idd;
	logic [10:0] ain;
	logic        ld_rs;
	logic        ld_ts;
	logic        ld_te;
	logic        snd_ab;
	logic [31:0] rd;
	logic        rd_ok;

	sdlcc_tx_t   tx_st;
	logic [2:0]  div;
	logic        tx_tick;
	logic [15:0] sh;
	logic [4:0]  bc;
	logic [2:0]  ones;
	logic [10:0] tx_start;
	logic [10:0] tx_end;
	logic [10:0] cur_end;
	logic [10:0] tx_ptr;
	logic        pend;
	logic        in_msg;
	logic        wlast;
	logic        ab_req;
	logic        ev_done;
	logic        ev_tx;
	logic        tx_clr;
	sdlcc_tx_t   id_st;
	logic [15:0] id_sh;
	logic [4:0]  id_bc;
	logic        id_go;

	logic        rc1;
	logic        rc2;
	logic        rc3;
	logic        rd1;
	logic        rd2;
	logic        rx_tick;
	logic        rx_en_q;
	logic [7:0]  hist;
	logic [3:0]  r_ones;
	logic [15:0] rw;
	logic [3:0]  r_bc;
	logic [10:0] rx_start;
	logic [10:0] rx_ptr;
	logic [10:0] rx_last;
	logic [10:0] rx_end;
	logic        rx_msg;
	logic        rx_rld;
	logic        ev_rx;
	logic        ev_ab;
	logic        ev_id;

	////////////////////////////////////////////////////////////////////
	// Bus slave.

	// Byte enables widen to a bit mask so every field but the frame-done clear obeys its lane.
	assign wm = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
		{8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

	// Address and data are caught separately and in either order.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			aw_h      <= 1'b0;
			w_h       <= 1'b0;
			wa        <= 8'h00;
			wd        <= 32'h0000_0000;
			wmq       <= 32'h0000_0000;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OK;
		end else begin
			o_awready <= i_awvalid && !o_awready && !aw_h && !o_bvalid;
			o_wready  <= i_wvalid && !o_wready && !w_h && !o_bvalid;
			if (o_awready && i_awvalid) begin
				aw_h <= 1'b1;
				wa   <= i_awaddr;
			end
			if (o_wready && i_wvalid) begin
				w_h <= 1'b1;
				wd  <= i_wdata & wm;
				wmq <= wm; // Strobes may move on once data is taken.
			end
			if (wr) begin
				aw_h     <= 1'b0;
				w_h      <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= (wr_ctl || wr_aux) ? RESP_OK : RESP_ERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Write effects happen once, in the cycle the response is raised.
	assign wr     = aw_h && w_h && !o_bvalid;
	assign wr_ctl = wr && (wa == A_CTL);
	assign wr_aux = wr && (wa == A_AUX);
	assign ain    = wd[B_AIN +: 11];
	assign ld_rs  = wr_ctl && wd[B_LRS];
	assign ld_ts  = wr_ctl && wd[B_LTS];
	assign ld_te  = wr_ctl && wd[B_LTE];
	assign snd_ab = wr_ctl && wd[B_ABT];

	// Read mux; bits with no readable field read back as zero.
	always_comb begin
		rd    = 32'h0000_0000;
		rd_ok = 1'b1;
		if (i_araddr == A_CTL) begin
			rd[B_IDD]        = idd;
			rd[B_ABD]        = abd;
			rd[B_REA +: 11]  = rx_end;
			rd[B_IADR]       = iad;
			rd[B_IADR + 1]   = iad;
			rd[B_SEND]       = (tx_st == TX_DATA);
			rd[B_FD]         = fd;
			rd[B_CTLW - 1:0] = ctl;
		end else if (i_araddr == A_AUX) begin
			rd[B_IST +: 4]   = ist;
			rd[B_TCE]        = tce;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel; an unmapped address answers SLVERR with zero data.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OK;
		end else begin
			o_arready <= i_arvalid && !o_arready && !o_rvalid;
			if (o_arready && i_arvalid) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd;
				o_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control and status registers.

	// In every latch below a hardware event beats a same-cycle clear.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl <= CTL_RST;
			iad <= 1'b0;
			tce <= 1'b0;
			fd  <= 1'b0;
			ist <= 4'h0;
			abd <= 1'b0;
			idd <= 1'b0;
		end else begin
			if (tx_clr)
				ctl[B_TXEN] <= 1'b0;
			if (wr_ctl) begin
				ctl <= (ctl & ~wmq[6:0]) | wd[6:0];
				if (wmq[B_IADW])
					iad <= wd[B_IADW];
			end
			if (wr_aux && wmq[B_TCE])
				tce <= wd[B_TCE];
			fd  <= ev_done || (fd && !wr_ctl);
			abd <= ev_ab || (abd && !(wr_ctl && wd[B_ABD]));
			idd <= ev_id || (idd && !(wr_ctl && wd[B_IDD]));
			// Order: transmit, frame done, receive, received abort.
			ist <= {ev_ab, ev_rx, ev_done, ev_tx}
				| (ist & ~({4{wr_aux}} & wd[B_IST +: 4]));
		end
	end

	// Status always latches; the enables gate only the lines.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			o_irq <= 4'h0;
		else
			o_irq <= ist & ctl[5:2];
	end

	////////////////////////////////////////////////////////////////////
	// Transmit bit clock.

	// Data changes as the outgoing clock falls, mid-way between rises.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div      <= 3'h0;
			o_tx_clk <= 1'b1;
		end else if (div == 3'(HALF_CYC - 1)) begin
			div      <= 3'h0;
			o_tx_clk <= !o_tx_clk;
		end else begin
			div <= div + 3'h1;
		end
	end
	assign tx_tick = (div == 3'(HALF_CYC - 1)) && o_tx_clk;

	////////////////////////////////////////////////////////////////////
	// Transmitter.

	// Next character once a character or mark ends outside a frame.
	always_comb begin
		id_go = 1'b0;
		id_st = TX_OFF;
		id_sh = 16'hFFFF;
		id_bc = 5'h01;
		if (ctl[B_TXEN] && pend) begin
			id_go = 1'b1;
			id_st = TX_FLAG;
			id_sh = {8'h00, FLAG};
			id_bc = 5'h08;
		end else if (!ctl[B_TXEN]) begin
			id_st = TX_OFF;
		end else if (iad) begin
			id_st = TX_MARK;
			if (tx_st != TX_MARK)
				id_bc = MARK_BITS;
		end else begin
			id_st = TX_FLAG;
			id_sh = {8'h00, FLAG};
			id_bc = 5'h08;
			if (ctl[6] && tx_st == TX_FLAG) begin
				id_sh = {9'h000, FLAG[7:1]};
				id_bc = 5'h07;
			end
		end
	end

	// Characters leave LSB first; data words get zero insertion.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_st     <= TX_OFF;
			o_tx_data <= 1'b1;
			sh        <= 16'hFFFF;
			bc        <= 5'h01;
			ones      <= 3'h0;
			tx_start  <= ADDR_RST;
			tx_end    <= ADDR_RST;
			cur_end   <= ADDR_RST;
			tx_ptr    <= ADDR_RST;
			pend      <= 1'b0;
			in_msg    <= 1'b0;
			wlast     <= 1'b0;
			ab_req    <= 1'b0;
			ev_done   <= 1'b0;
			ev_tx     <= 1'b0;
			tx_clr    <= 1'b0;
		end else begin
			ev_done <= 1'b0;
			ev_tx   <= 1'b0;
			tx_clr  <= 1'b0;
			if (snd_ab && in_msg)
				ab_req <= 1'b1;
			if (tx_tick && ab_req && in_msg) begin
				tx_st     <= TX_ABRT;
				o_tx_data <= TX_ABORT[0];
				sh        <= {9'h1FF, TX_ABORT[7:1]};
				bc        <= 5'h07;
				in_msg    <= 1'b0;
				ab_req    <= 1'b0;
				ones      <= 3'h0;
			end else if (tx_tick && tx_st == TX_DATA) begin
				if (ones == STUFF_RUN) begin
					o_tx_data <= 1'b0;
					ones      <= 3'h0;
				end else begin
					o_tx_data <= sh[0];
					ones      <= sh[0] ? ones + 3'h1 : 3'h0;
					if (bc != 5'h01) begin
						sh <= {1'b1, sh[15:1]};
						bc <= bc - 5'h01;
					end else if (!wlast) begin
						sh     <= i_tx_ram_data;
						bc     <= 5'h10;
						wlast  <= (tx_ptr == cur_end);
						tx_ptr <= tx_ptr + 11'h001;
					end else begin
						// Closing flag: the frame is complete.
						tx_st   <= TX_FLAG;
						sh      <= {8'h00, FLAG};
						bc      <= 5'h08;
						in_msg  <= 1'b0;
						ev_done <= 1'b1;
						ev_tx   <= !pend;
						tx_clr  <= !pend && tce;
					end
				end
			end else if (tx_tick && tx_st == TX_FLAG && ones == STUFF_RUN) begin
				// Data ending on five ones still owes its zero, or the
				// far end would swallow the closing flag's first bit.
				o_tx_data <= 1'b0;
				ones      <= 3'h0;
			end else if (tx_tick) begin
				o_tx_data <= sh[0];
				ab_req    <= 1'b0;
				if (bc != 5'h01) begin
					sh <= {1'b1, sh[15:1]};
					bc <= bc - 5'h01;
				end else if (tx_st == TX_FLAG && in_msg) begin
					tx_st  <= TX_DATA;
					sh     <= i_tx_ram_data;
					bc     <= 5'h10;
					ones   <= 3'h0;
					wlast  <= (tx_ptr == cur_end);
					tx_ptr <= tx_ptr + 11'h001;
				end else begin
					tx_st <= id_st;
					sh    <= id_sh;
					bc    <= id_bc;
					if (id_go) begin
						in_msg   <= 1'b1;
						tx_ptr   <= tx_start;
						cur_end  <= tx_end;
						tx_start <= tx_end + 11'h001;
						pend     <= 1'b0;
					end
				end
			end
			// Software loads come last so they win over the above.
			if (ld_ts)
				tx_start <= ain;
			if (ld_te) begin
				tx_end <= ain;
				pend   <= 1'b1;
			end
		end
	end

	assign o_tx_ram_addr = tx_ptr;

	////////////////////////////////////////////////////////////////////
	// Receiver.

	// Two stages guard against metastability on the link inputs.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rc1 <= 1'b0;
			rc2 <= 1'b0;
			rc3 <= 1'b0;
			rd1 <= 1'b1;
			rd2 <= 1'b1;
		end else begin
			rc1 <= i_rx_clk;
			rc2 <= rc1;
			rc3 <= rc2;
			rd1 <= i_rx_data;
			rd2 <= rd1;
		end
	end
	assign rx_tick = rc2 && !rc3;

	// Bits are taken on the rising remote clock; runs of ones mark
	// stuffing, abort and idle, and a flag closes a started frame.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_en_q       <= 1'b0;
			hist          <= 8'h00;
			r_ones        <= 4'h0;
			rw            <= 16'h0000;
			r_bc          <= 4'h0;
			rx_start      <= ADDR_RST;
			rx_ptr        <= ADDR_RST;
			rx_last       <= ADDR_RST;
			rx_end        <= ADDR_RST;
			rx_msg        <= 1'b0;
			rx_rld        <= 1'b0;
			o_rx_ram_addr <= ADDR_RST;
			o_rx_ram_data <= 16'h0000;
			o_rx_ram_we   <= 1'b0;
			ev_rx         <= 1'b0;
			ev_ab         <= 1'b0;
			ev_id         <= 1'b0;
		end else begin
			rx_en_q     <= ctl[B_RXEN];
			o_rx_ram_we <= 1'b0;
			ev_rx       <= 1'b0;
			ev_ab       <= 1'b0;
			ev_id       <= 1'b0;
			if (ctl[B_RXEN] && !rx_en_q) begin
				rx_ptr <= rx_start;
				rx_msg <= 1'b0;
				r_bc   <= 4'h0;
			end else if (rx_tick && ctl[B_RXEN]) begin
				hist   <= {rd2, hist[7:1]};
				r_ones <= !rd2 ? 4'h0 :
					(r_ones == 4'hF) ? r_ones : r_ones + 4'h1;
				if (rd2 && r_ones == RX_IDLE)
					ev_id <= 1'b1;
				if ({rd2, hist[7:1]} == FLAG) begin
					r_bc <= 4'h0;
					if (rx_msg) begin
						rx_msg <= 1'b0;
						rx_end <= rx_last;
						ev_rx  <= 1'b1;
						rx_rld <= 1'b0;
						if (rx_rld)
							rx_ptr <= rx_start;
					end
				end else if (rd2 && r_ones == RX_ABORT) begin
					ev_ab  <= 1'b1;
					rx_msg <= 1'b0;
					r_bc   <= 4'h0;
				end else if (!rd2 && r_ones == 4'(STUFF_RUN)) begin
					r_bc <= r_bc; // Inserted zero, dropped.
				end else if (r_ones < 4'h6) begin
					rw   <= {rd2, rw[15:1]};
					r_bc <= r_bc + 4'h1;
					if (r_bc == 4'hF) begin
						o_rx_ram_data <= {rd2, rw[15:1]};
						o_rx_ram_addr <= rx_ptr;
						o_rx_ram_we   <= 1'b1;
						rx_last       <= rx_ptr;
						rx_ptr        <= rx_ptr + 11'h001;
						rx_msg        <= 1'b1;
					end
				end
			end
			// A new start applies now between frames, else at frame end.
			if (ld_rs) begin
				rx_start <= ain;
				if (rx_msg)
					rx_rld <= 1'b1;
				else
					rx_ptr <= ain;
			end
		end
	end

endmodule : sdlcc_top

`default_nettype wire
